// >>> pcs_pkg.sv
// constants for the phy control tail and status register block
`default_nettype none
package pcs_pkg;
   localparam int          APB_AW       = 8;
   localparam int          APB_DW       = 32;
   localparam int          REG_W        = 16;
   // register indices; byte address is four times the index
   localparam int          CTRL_IDX     = 0;
   localparam int          STAT_IDX     = 1;
   localparam logic [7:0]  CTRL_ADDR    = 8'(CTRL_IDX * 4);
   localparam logic [7:0]  STAT_ADDR    = 8'(STAT_IDX * 4);
   // control field positions
   localparam int          C_SPD_MSB    = 13;
   localparam int          C_AN_EN      = 12;
   localparam int          C_DUPLEX     = 8;
   localparam int          C_SPD_LSB    = 6;
   localparam int          C_UNIDIR     = 5;
   localparam int          C_RSVD_HI    = 4;
   // status field positions
   localparam int          S_ABIL_HI    = 15;
   localparam int          S_ABIL_LO    = 9;
   localparam int          S_EXT_STAT   = 8;
   localparam int          S_UNI_ABLE   = 7;
   localparam int          S_SHORT_HDR  = 6;
   localparam int          S_AN_DONE    = 5;
   localparam int          S_RFAULT     = 4;
   localparam int          S_AN_ABLE    = 3;
   localparam int          S_LINK       = 2;
   localparam int          S_JABBER     = 1;
   localparam int          S_EXT_CAP    = 0;
   localparam int          ABIL_W       = S_ABIL_HI - S_ABIL_LO + 1;
   // reset values
   localparam logic        DUPLEX_RST   = 1'b0;
   typedef enum logic [1:0] {
      SPD_10,
      SPD_100,
      SPD_1000,
      SPD_RSVD
   } pcs_speed_type;
endpackage
`default_nettype wire

// >>> pcs_regs.sv
// phy control tail and status registers behind an apb slave
`default_nettype none
module pcs_regs #(
   parameter logic [pcs_pkg::ABIL_W-1:0] ABILITY     = 7'h7f,
   parameter logic                       EXT_STATUS  = 1'b1,
   parameter logic                       UNI_ABLE    = 1'b1,
   parameter logic                       DOWNSTREAM  = 1'b0,
   parameter logic                       SHORT_HDR   = 1'b1,
   parameter logic                       AN_ABLE     = 1'b1,
   parameter logic                       EXT_CAP     = 1'b1,
   parameter logic                       FAST_PHY    = 1'b1,
   parameter logic                       SPD_MSB_RST = 1'b1,
   parameter logic                       SPD_LSB_RST = 1'b0
) (
   input  wire logic                        I_CLOCK,
   input  wire logic                        I_RST,
   input  wire logic                        I_PSEL,
   input  wire logic                        I_PENABLE,
   input  wire logic                        I_PWRITE,
   input  wire logic [pcs_pkg::APB_AW-1:0]  I_PADDR,
   input  wire logic [pcs_pkg::APB_DW-1:0]  I_PWDATA,
   input  wire logic [3:0]                  I_PSTRB,
   output logic      [pcs_pkg::APB_DW-1:0]  O_PRDATA,
   output logic                             O_PREADY,
   output logic                             O_PSLVERR,
   input  wire logic                        I_LINK_OK,
   input  wire logic                        I_REMOTE_FAULT,
   input  wire logic                        I_JABBER,
   input  wire logic                        I_AN_COMPLETE,
   input  wire logic [1:0]                  I_AN_SPEED,
   output logic      [1:0]                  O_SPEED,
   output logic                             O_AN_ENABLE,
   output logic                             O_FULL_DUPLEX,
   output logic                             O_TX_PERMIT
);

   localparam logic UNI_RST = UNI_ABLE & DOWNSTREAM;
   localparam logic AN_RST  = AN_ABLE;
   localparam int   PAD_W   = pcs_pkg::APB_DW - pcs_pkg::REG_W;

   logic                        spd_msb_r;
   logic                        spd_lsb_r;
   logic                        an_en_r;
   logic                        duplex_r;
   logic                        uni_r;
   logic                        rfault_r;
   logic                        jabber_r;
   logic                        link_r;
   logic [pcs_pkg::APB_DW-1:0]  prdata_r;
   logic                        ctrl_hit;
   logic                        stat_hit;
   logic                        setup;
   logic                        access;
   logic                        ctrl_wr;
   logic                        stat_rd;
   logic                        stat_wr;
   logic                        an_done;
   logic                        uni_eff;
   logic                        wr_lo;
   logic                        wr_hi;
   logic [pcs_pkg::REG_W-1:0]   ctrl_word;
   logic [pcs_pkg::REG_W-1:0]   stat_word;
   pcs_pkg::pcs_speed_type      speed_r;
   logic                        tx_permit_r;

   ////////////////////////////////////////////////////////////////////////
   // manual speed code; the reserved pair keeps a code of its own so that
   // a stray write is never mistaken for a legal speed
   function automatic pcs_pkg::pcs_speed_type pcs_decode_speed(
      input logic msb,
      input logic lsb
   );
      case ({lsb, msb})
         2'h0: pcs_decode_speed = pcs_pkg::SPD_10;
         2'h1: pcs_decode_speed = pcs_pkg::SPD_100;
         2'h2: pcs_decode_speed = pcs_pkg::SPD_1000;
         default: pcs_decode_speed = pcs_pkg::SPD_RSVD;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // bus decode: zero wait states, ready follows the access phase
   assign setup     = I_PSEL & ~I_PENABLE;
   assign access    = I_PSEL & I_PENABLE;
   assign ctrl_hit  = (I_PADDR == pcs_pkg::CTRL_ADDR);
   assign stat_hit  = (I_PADDR == pcs_pkg::STAT_ADDR);
   assign ctrl_wr   = access & I_PWRITE & ctrl_hit;
   // status writes are decoded only so the checks below can watch them
   assign stat_wr   = access & I_PWRITE & stat_hit;
   // snapshot and clear-on-read share the setup edge of a status read
   assign stat_rd   = setup & ~I_PWRITE & stat_hit;
   assign wr_lo     = ctrl_wr & I_PSTRB[0];
   assign wr_hi     = ctrl_wr & I_PSTRB[1];
   assign O_PREADY  = access;
   assign O_PSLVERR = access & ~(ctrl_hit | stat_hit);

   ////////////////////////////////////////////////////////////////////////
   // control bits
   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         spd_msb_r <= SPD_MSB_RST;
      end else if (wr_hi) begin
         spd_msb_r <= I_PWDATA[pcs_pkg::C_SPD_MSB];
      end
   end

   // without the ability a written one is simply dropped
   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         an_en_r <= AN_RST;
      end else if (wr_hi) begin
         an_en_r <= I_PWDATA[pcs_pkg::C_AN_EN] & AN_ABLE;
      end
   end

   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         duplex_r <= pcs_pkg::DUPLEX_RST;
      end else if (wr_hi) begin
         duplex_r <= I_PWDATA[pcs_pkg::C_DUPLEX];
      end
   end

   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         spd_lsb_r <= SPD_LSB_RST;
      end else if (wr_lo) begin
         spd_lsb_r <= I_PWDATA[pcs_pkg::C_SPD_LSB];
      end
   end

   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         uni_r <= UNI_RST;
      end else if (wr_lo) begin
         uni_r <= I_PWDATA[pcs_pkg::C_UNIDIR] & UNI_ABLE;
      end
   end

   always_comb begin
      ctrl_word                     = '0;
      ctrl_word[pcs_pkg::C_SPD_MSB] = spd_msb_r;
      ctrl_word[pcs_pkg::C_AN_EN]   = an_en_r;
      ctrl_word[pcs_pkg::C_DUPLEX]  = duplex_r;
      ctrl_word[pcs_pkg::C_SPD_LSB] = spd_lsb_r;
      ctrl_word[pcs_pkg::C_UNIDIR]  = uni_r;
   end

   ////////////////////////////////////////////////////////////////////////
   // status bits
   assign an_done = AN_ABLE & an_en_r & I_AN_COMPLETE;

   always_comb begin
      stat_word = '0;
      stat_word[pcs_pkg::S_ABIL_HI:pcs_pkg::S_ABIL_LO] = ABILITY;
      stat_word[pcs_pkg::S_EXT_STAT]  = EXT_STATUS;
      stat_word[pcs_pkg::S_UNI_ABLE]  = UNI_ABLE;
      stat_word[pcs_pkg::S_SHORT_HDR] = SHORT_HDR;
      stat_word[pcs_pkg::S_AN_DONE]   = an_done;
      stat_word[pcs_pkg::S_RFAULT]    = rfault_r;
      stat_word[pcs_pkg::S_AN_ABLE]   = AN_ABLE;
      stat_word[pcs_pkg::S_LINK]      = link_r;
      stat_word[pcs_pkg::S_JABBER]    = jabber_r & ~FAST_PHY;
      stat_word[pcs_pkg::S_EXT_CAP]   = EXT_CAP;
   end

   // latched flags: a new event wins over the clear of the same read, so
   // an event never slips between snapshot and clear
   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         rfault_r <= 1'h0;
      end else if (I_REMOTE_FAULT) begin
         rfault_r <= 1'h1;
      end else if (stat_rd) begin
         rfault_r <= 1'h0;
      end
   end

   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         jabber_r <= 1'h0;
      end else if (I_JABBER & ~FAST_PHY) begin
         jabber_r <= 1'h1;
      end else if (stat_rd) begin
         jabber_r <= 1'h0;
      end
   end

   // link reads down after reset and on the first status read, which sets it
   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         link_r <= 1'h0;
      end else if (~I_LINK_OK) begin
         link_r <= 1'h0;
      end else if (stat_rd) begin
         link_r <= 1'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data is loaded in the setup phase so it stands through access
   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         prdata_r <= '0;
      end else if (setup & ~I_PWRITE) begin
         if (stat_hit) begin
            prdata_r <= {{PAD_W{1'b0}}, stat_word};
         end else if (ctrl_hit) begin
            prdata_r <= {{PAD_W{1'b0}}, ctrl_word};
         end else begin
            prdata_r <= '0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // link configuration seen by the datapath
   assign uni_eff = uni_r & ~an_en_r & duplex_r;

   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         speed_r <= pcs_decode_speed(SPD_MSB_RST, SPD_LSB_RST);
      end else if (an_en_r) begin
         speed_r <= pcs_pkg::pcs_speed_type'(I_AN_SPEED);
      end else begin
         speed_r <= pcs_decode_speed(spd_msb_r, spd_lsb_r);
      end
   end

   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         tx_permit_r <= 1'h0;
      end else begin
         tx_permit_r <= uni_eff | I_LINK_OK;
      end
   end

   assign O_PRDATA      = prdata_r;
   assign O_SPEED       = speed_r;
   assign O_AN_ENABLE   = an_en_r;
   assign O_FULL_DUPLEX = duplex_r;
   assign O_TX_PERMIT   = tx_permit_r;

   ////////////////////////////////////////////////////////////////////////
   // checks
   rsvd_zero_a: assert property (
      @(posedge I_CLOCK) disable iff (I_RST)
      (access && !I_PWRITE && ctrl_hit)
      |-> (O_PRDATA[pcs_pkg::C_RSVD_HI:0] == '0))
      else $error("reserved control bits read back nonzero");

   uni_able_a: assert property (
      @(posedge I_CLOCK) disable iff (I_RST)
      uni_r |-> UNI_ABLE)
      else $error("unidirectional enable set without ability");

   tx_permit_a: assert property (
      @(posedge I_CLOCK) disable iff (I_RST)
      !$past(I_RST) |-> (O_TX_PERMIT == $past(uni_eff | I_LINK_OK)))
      else $error("transmit permit disagrees with mode and link");

   stat_ro_a: assert property (
      @(posedge I_CLOCK) disable iff (I_RST)
      stat_wr |=> $stable(ctrl_word))
      else $error("status write changed a control bit");

   an_done_a: assert property (
      @(posedge I_CLOCK) disable iff (I_RST)
      !an_en_r |-> !an_done)
      else $error("autoneg complete shown while autoneg disabled");

   jabber_zero_a: assert property (
      @(posedge I_CLOCK) disable iff (I_RST)
      (access && !I_PWRITE && stat_hit && FAST_PHY)
      |-> !O_PRDATA[pcs_pkg::S_JABBER])
      else $error("jabber read as one on a fast phy");

   link_hold_a: assert property (
      @(posedge I_CLOCK) disable iff (I_RST)
      !I_LINK_OK |=> !link_r)
      else $error("link status not latched low after failure");

   fault_latch_a: assert property (
      @(posedge I_CLOCK) disable iff (I_RST)
      I_REMOTE_FAULT |=> rfault_r)
      else $error("remote fault not latched");
endmodule
`default_nettype wire

// >>> phy_ctrl_tail_and_status_regs_test.sv
// bench for the phy control tail and status registers
`default_nettype none
module phy_ctrl_tail_and_status_regs_test;
   timeunit 1ns / 1ns;
   logic        clk = 0, rst = 1, ps = 0, pe = 0, pw = 0;
   logic [2:0]  ev = 1;
   logic [7:0]  pa = 0;
   logic [31:0] wd = 0, q, q_b;
   int          fail_count = 0, total_checks = 0, cyc = 0;
   wire logic        rdy, txp, txp_b;
   wire logic [1:0]  spd, spd_b;
   wire logic [31:0] rd, rd_b;
   pcs_regs uut (.I_CLOCK(clk), .I_RST(rst), .I_PSEL(ps), .I_PENABLE(pe),
      .I_PWRITE(pw), .I_PADDR(pa), .I_PWDATA(wd), .I_PSTRB(4'hf),
      .O_PRDATA(rd), .O_PREADY(rdy), .O_PSLVERR(), .I_LINK_OK(!ev[0]),
      .I_REMOTE_FAULT(ev[2]), .I_JABBER(ev[1]), .I_AN_COMPLETE(1'h1),
      .I_AN_SPEED(2'h0), .O_SPEED(spd), .O_AN_ENABLE(),
      .O_FULL_DUPLEX(), .O_TX_PERMIT(txp));
   // a second phy without unidirectional, autoneg or fast-phy traits
   pcs_regs #(.UNI_ABLE(1'h0), .AN_ABLE(1'h0), .FAST_PHY(1'h0)) uut_b (
      .I_CLOCK(clk), .I_RST(rst), .I_PSEL(ps), .I_PENABLE(pe),
      .I_PWRITE(pw), .I_PADDR(pa), .I_PWDATA(wd), .I_PSTRB(4'hf),
      .O_PRDATA(rd_b), .O_PREADY(), .O_PSLVERR(), .I_LINK_OK(!ev[0]),
      .I_REMOTE_FAULT(ev[2]), .I_JABBER(ev[1]), .I_AN_COMPLETE(1'h1),
      .I_AN_SPEED(2'h0), .O_SPEED(spd_b), .O_AN_ENABLE(),
      .O_FULL_DUPLEX(), .O_TX_PERMIT(txp_b));
   initial forever #4 clk = ~clk;
   always @(posedge clk) if (++cyc == 3000) conclude(1);
   task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      {ps, pw, pa, wd} <= {1'h1, w, a, d};
      @(posedge clk);
      pe <= 1'h1;
      do @(posedge clk); while (rdy !== 1'h1);
      q = rd;
      q_b = rd_b;
      {ps, pe} <= 2'h0;
   endtask
   task automatic chk(logic [31:0] got, exp);
      total_checks++;
      if (got !== exp) fail_count++;
      if (got !== exp) $display("BAD t=%0t got %h exp %h", $time, got, exp);
   endtask
   task automatic conclude(int bad);
      $display("checks %0d bad %0d", total_checks, fail_count + bad);
      if (fail_count + bad == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic t_ctrl();
      xfer(1'h0, pcs_pkg::CTRL_ADDR, 32'h0);
      chk(q[5:0], 6'h0);
      xfer(1'h1, pcs_pkg::CTRL_ADDR, 32'h213f);
      xfer(1'h0, pcs_pkg::CTRL_ADDR, 32'h0);
      chk(q[5:0], 6'h20);
      chk(q_b[5:0], 6'h0);
      chk({txp, spd}, {1'h1, pcs_pkg::SPD_100});
      xfer(1'h1, pcs_pkg::CTRL_ADDR, 32'h1120);
      xfer(1'h0, pcs_pkg::CTRL_ADDR, 32'h0);
      chk(txp, 1'h0);
      chk(spd_b, pcs_pkg::SPD_10);
      $display("control test done");
   endtask
   task automatic t_stat();
      ev <= 3'h7;
      @(posedge clk);
      ev <= 3'h0;
      xfer(1'h0, pcs_pkg::STAT_ADDR, 32'h0);
      chk(q, 32'hfff9);
      chk(q_b, 32'hff53);
      xfer(1'h1, pcs_pkg::STAT_ADDR, 32'h0);
      xfer(1'h0, pcs_pkg::STAT_ADDR, 32'h0);
      chk(q, 32'hffed);
      chk(q_b, 32'hff45);
      $display("status test done");
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'h0;
      t_ctrl();
      t_stat();
      conclude(0);
   end
endmodule
`default_nettype wire
